// ===== include/fsr_pkg.sv
package fsr_pkg;
   // field positions inside status_two
   localparam int unsigned PAUSED_BIT = 7;
   localparam int unsigned INVERT_BIT = 6;
   localparam int unsigned LOCK_HI_BIT = 5;
   localparam int unsigned LOCK_LO_BIT = 3;
   localparam int unsigned QUAD_BIT = 1;
   localparam int unsigned GUARD_HI_BIT = 0;
   localparam int unsigned LOCK_COUNT = 3;
   // reset values
   localparam logic RST_PAUSED = 1'b0;
   localparam logic RST_INVERT = 1'b0;
   localparam logic RST_QUAD = 1'b0;
   localparam logic RST_GUARD_HI = 1'b0;
   localparam logic RST_LOCK = 1'b0;
   // command opcodes
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;
   localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
   localparam logic [7:0] OP_RESET_DEVICE = 8'h99;
   localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
   localparam logic [7:0] OP_XIP_READ = 8'heb;
   localparam logic [7:0] OP_QUAD_PAGE_PROG = 8'h32;
   localparam logic [7:0] OP_BURST_WRAP = 8'h77;
   localparam logic [7:0] OP_QUAD_ID_READ = 8'h94;
   // security registers
   localparam logic [1:0] SEC_FACTORY_SEL = 2'h0;
   localparam logic [6:0] SEC_LAST_BYTE = 7'h7f;
endpackage : fsr_pkg

// ===== logic/fsr_lock_cell.sv
`timescale 1ns/1ps
module fsr_lock_cell (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // set request
   input wire logic set_pulse,
   // sticky state
   output logic locked
);
   typedef struct packed {
      logic locked;
   } fsr_cell_state_t;

   fsr_cell_state_t state_ff;
   fsr_cell_state_t nxt_state;

   // one-time lock: nothing but reset can clear it
   always_comb begin
      nxt_state = state_ff;
      if (set_pulse) begin
         nxt_state.locked = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff.locked <= fsr_pkg::RST_LOCK;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign locked = state_ff.locked;
endmodule : fsr_lock_cell

// ===== logic/fsr_status_two.sv
// Functional notes
// - suspend flag bit 7 set by 75h
// - resume, JEDEC reset, hold reset (quad off only) or 66h/99h clear suspend
// - bit 6 inverts protection map
// - lock flags bits 5:3, regs 3..1
// - last byte program sets lock flag
// - locked security register refuses programs
// - security register 0 always locked
// - bit 1 quad enable permits quad/xip
// - quad off: pins keep control functions
// - quad on: pins become data 2/3
// - quad enable gates five listed commands only
// - bit 0 upper guard selects protection
// - guards 0,1 with pin high: writable
// - guards 1,1 with perm lock: never
`timescale 1ns/1ps
module fsr_status_two (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // executed command from the sequencer
   input wire logic cmd_exec,
   input wire logic [7:0] cmd_code,
   // reset events
   input wire logic hold_reset_pulse,
   input wire logic jedec_reset_pulse,
   // status register write
   input wire logic sr_wr_strobe,
   input wire logic [7:0] sr_wr_data,
   input wire logic wel,
   input wire logic status_guard_lo,
   input wire logic status_perm_lock,
   input wire logic wp_n,
   output logic sr_wr_accept,
   // security register program
   input wire logic sec_prog_strobe,
   input wire logic [1:0] sec_prog_sel,
   input wire logic [6:0] sec_prog_addr,
   output logic sec_prog_ok,
   // quad mode and pin functions
   output logic quad_cmd_ok,
   output logic io2_data_mode,
   output logic io3_data_mode,
   output logic wp_func_en,
   output logic hold_reset_func_en,
   // array protection check
   input wire logic region_prot_raw,
   output logic region_protected,
   // register readback
   output logic [7:0] status_two
);
   typedef struct packed {
      logic paused_op_flag;
      logic invert_protection;
      logic quad_enable;
      logic status_guard_hi;
      logic reset_armed;
   } fsr_state_t;

   fsr_state_t state_ff;
   fsr_state_t nxt_state;
   logic [fsr_pkg::LOCK_COUNT-1:0] security_lock_bits;
   logic [fsr_pkg::LOCK_COUNT-1:0] lock_set;
   logic sw_reset;
   logic hw_reset;
   logic any_reset;
   logic wp_level;
   logic quad_cmd;
   logic sel_locked;

   // the hold/reset pin is a data line in quad mode, so its reset is dropped
   assign hw_reset = (hold_reset_pulse & ~state_ff.quad_enable) | jedec_reset_pulse;
   assign sw_reset = cmd_exec & (cmd_code == fsr_pkg::OP_RESET_DEVICE) & state_ff.reset_armed;
   assign any_reset = hw_reset | sw_reset;

   // a write-protect pin used as data is read as high
   assign wp_level = state_ff.quad_enable ? 1'b1 : wp_n;

   // guard_hi set covers both lockdown and the permanent case
   assign sr_wr_accept = sr_wr_strobe & wel & ~state_ff.status_guard_hi
      & ~(status_guard_lo & ~wp_level);

   assign quad_cmd = (cmd_code == fsr_pkg::OP_QUAD_OUT_READ) | (cmd_code == fsr_pkg::OP_XIP_READ)
      | (cmd_code == fsr_pkg::OP_QUAD_PAGE_PROG) | (cmd_code == fsr_pkg::OP_BURST_WRAP)
      | (cmd_code == fsr_pkg::OP_QUAD_ID_READ);
   assign quad_cmd_ok = quad_cmd ? state_ff.quad_enable : 1'b1;

   assign io2_data_mode = state_ff.quad_enable;
   assign io3_data_mode = state_ff.quad_enable;
   assign wp_func_en = ~state_ff.quad_enable;
   assign hold_reset_func_en = ~state_ff.quad_enable;

   assign region_protected = region_prot_raw ^ state_ff.invert_protection;

   // register 0 is factory content and has no lock flag
   always_comb begin
      sel_locked = 1'b1;
      if (sec_prog_sel != fsr_pkg::SEC_FACTORY_SEL) begin
         sel_locked = security_lock_bits[2'(sec_prog_sel - 2'h1)];
      end
   end
   assign sec_prog_ok = sec_prog_strobe & ~sel_locked;

   genvar gi;
   generate
      for (gi = 0; gi < fsr_pkg::LOCK_COUNT; gi++) begin : g_lock
         assign lock_set[gi] = sec_prog_ok & (sec_prog_sel == 2'(gi + 1))
            & (sec_prog_addr == fsr_pkg::SEC_LAST_BYTE);
         fsr_lock_cell u_lock (
            .core_clk(core_clk),
            .resetn(resetn),
            .set_pulse(lock_set[gi]),
            .locked(security_lock_bits[gi])
         );
      end
   endgenerate

   always_comb begin
      nxt_state = state_ff;
      if (cmd_exec) begin
         nxt_state.reset_armed = (cmd_code == fsr_pkg::OP_RESET_ENABLE);
      end
      if (sr_wr_accept) begin
         // read-only positions of the written byte are dropped
         nxt_state.invert_protection = sr_wr_data[fsr_pkg::INVERT_BIT];
         nxt_state.quad_enable = sr_wr_data[fsr_pkg::QUAD_BIT];
         nxt_state.status_guard_hi = sr_wr_data[fsr_pkg::GUARD_HI_BIT];
      end
      if (any_reset) begin
         nxt_state.paused_op_flag = 1'b0;
         // lockdown ends at reset; the permanent combination survives it
         if (!(status_guard_lo & status_perm_lock)) begin
            nxt_state.status_guard_hi = 1'b0;
         end
      end
      if (cmd_exec && cmd_code == fsr_pkg::OP_RESUME) begin
         nxt_state.paused_op_flag = 1'b0;
      end
      // set wins over any clear in the same cycle
      if (cmd_exec && cmd_code == fsr_pkg::OP_SUSPEND) begin
         nxt_state.paused_op_flag = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff.paused_op_flag <= fsr_pkg::RST_PAUSED;
         state_ff.invert_protection <= fsr_pkg::RST_INVERT;
         state_ff.quad_enable <= fsr_pkg::RST_QUAD;
         state_ff.status_guard_hi <= fsr_pkg::RST_GUARD_HI;
         state_ff.reset_armed <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_comb begin
      status_two = 8'h00;
      status_two[fsr_pkg::PAUSED_BIT] = state_ff.paused_op_flag;
      status_two[fsr_pkg::INVERT_BIT] = state_ff.invert_protection;
      status_two[fsr_pkg::LOCK_HI_BIT:fsr_pkg::LOCK_LO_BIT] = security_lock_bits;
      status_two[fsr_pkg::QUAD_BIT] = state_ff.quad_enable;
      status_two[fsr_pkg::GUARD_HI_BIT] = state_ff.status_guard_hi;
   end

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence s_suspend_cmd;
      cmd_exec && cmd_code == fsr_pkg::OP_SUSPEND;
   endsequence

   sequence s_resume_cmd;
      cmd_exec && cmd_code == fsr_pkg::OP_RESUME && !(cmd_code == fsr_pkg::OP_SUSPEND);
   endsequence

   // the host leaves one idle cycle between executed commands
   sequence s_sw_reset_pair;
      (cmd_exec && cmd_code == fsr_pkg::OP_RESET_ENABLE) ##1 !cmd_exec ##1
      (cmd_exec && cmd_code == fsr_pkg::OP_RESET_DEVICE);
   endsequence

   a_suspend_sets: assert property (s_suspend_cmd |=> status_two[7] ##1 1)
      else $error("suspend flag not set after suspend command");

   a_resume_clears: assert property (s_resume_cmd |=> !status_two[7])
      else $error("suspend flag not cleared by resume");

   a_swreset_clears: assert property (s_sw_reset_pair |=> !status_two[7] && !$past(cmd_code == 8'h75))
      else $error("suspend flag survived software reset");

   a_flag_no_spurious: assert property ($rose(status_two[7]) |-> $past(cmd_exec && cmd_code == 8'h75))
      else $error("suspend flag rose without suspend command");

   a_invert_map: assert property (region_protected == (region_prot_raw != status_two[6]))
      else $error("protection map not inverted by invert bit");

   a_lock_sticky: assert property ($fell(status_two[3]) |-> 1'b0)
      else $error("security lock flag cleared");

   a_lock_last_byte: assert property (
      sec_prog_ok && sec_prog_sel == 2'h2 && sec_prog_addr == 7'h7f |=> status_two[4])
      else $error("lock flag not set by last byte program");

   a_locked_refused: assert property (
      sec_prog_strobe && sec_prog_sel == 2'h3 && status_two[5] |-> !sec_prog_ok)
      else $error("program of locked security register accepted");

   a_factory_refused: assert property (sec_prog_sel == 2'h0 |-> !sec_prog_ok)
      else $error("program of factory security register accepted");

   a_quad_pins: assert property (
      io2_data_mode == status_two[1] && wp_func_en == !status_two[1]
      && hold_reset_func_en == !io3_data_mode)
      else $error("pin function does not follow quad enable");

   a_quad_gate: assert property (cmd_code == 8'h6b && !status_two[1] |-> !quad_cmd_ok)
      else $error("quad command permitted with quad disabled");

   a_write_takes: assert property (
      sr_wr_accept |=> status_two[1] == $past(sr_wr_data[1])
      && status_two[6] == $past(sr_wr_data[6]) && status_two[5:3] >= $past(status_two[5:3]))
      else $error("accepted write did not update writable bits");

   a_guard_refuses: assert property (status_two[0] |-> !sr_wr_accept)
      else $error("write accepted while upper guard set");

   a_hw_guard: assert property (
      sr_wr_strobe && wel && !status_two[0] && status_guard_lo && wp_n |-> sr_wr_accept)
      else $error("write refused with pin high and guards 0,1");
endmodule : fsr_status_two

// ===== bench/fsr_host_model.sv
`timescale 1ns/1ps
module fsr_host_model (
   // clock
   input wire logic core_clk,
   // commands and reset events
   output logic cmd_exec,
   output logic [7:0] cmd_code,
   input wire logic quad_cmd_ok,
   output logic hold_reset_pulse,
   output logic jedec_reset_pulse,
   // status write
   output logic sr_wr_strobe,
   output logic [7:0] sr_wr_data,
   input wire logic sr_wr_accept,
   // security program
   output logic sec_prog_strobe,
   output logic [1:0] sec_prog_sel,
   output logic [6:0] sec_prog_addr,
   input wire logic sec_prog_ok
);
   initial begin
      {cmd_exec, hold_reset_pulse, jedec_reset_pulse, sr_wr_strobe, sec_prog_strobe} = 5'h00;
      {cmd_code, sr_wr_data, sec_prog_sel, sec_prog_addr} = 25'h0;
   end
   // released fields except sec_prog_sel are inverted so a stale value never looks valid
   task automatic cmd(input logic [7:0] op, output logic ok);
      @(posedge core_clk);
      cmd_exec <= 1'b1;
      cmd_code <= op;
      #1;
      ok = quad_cmd_ok;
      @(posedge core_clk);
      cmd_exec <= 1'b0;
      cmd_code <= ~op;
      #1;
   endtask : cmd
   task automatic reset_event(input logic jedec);
      @(posedge core_clk);
      hold_reset_pulse <= ~jedec;
      jedec_reset_pulse <= jedec;
      @(posedge core_clk);
      {hold_reset_pulse, jedec_reset_pulse} <= 2'h0;
      #1;
   endtask : reset_event
   task automatic wr(input logic [7:0] d, output logic ok);
      @(posedge core_clk);
      sr_wr_strobe <= 1'b1;
      sr_wr_data <= d;
      #1;
      ok = sr_wr_accept;
      @(posedge core_clk);
      sr_wr_strobe <= 1'b0;
      sr_wr_data <= ~d;
      #1;
   endtask : wr
   task automatic prog(input logic [1:0] sel, input logic [6:0] addr, output logic ok);
      @(posedge core_clk);
      sec_prog_strobe <= 1'b1;
      sec_prog_sel <= sel;
      sec_prog_addr <= addr;
      #1;
      ok = sec_prog_ok;
      @(posedge core_clk);
      sec_prog_strobe <= 1'b0;
      sec_prog_addr <= ~addr;
      #1;
   endtask : prog
endmodule : fsr_host_model

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
   logic core_clk, resetn, wel, status_guard_lo, status_perm_lock, wp_n, region_prot_raw;
   logic cmd_exec, hold_reset_pulse, jedec_reset_pulse, sr_wr_strobe, sr_wr_accept, sec_prog_strobe;
   logic sec_prog_ok, quad_cmd_ok, io2_data_mode, io3_data_mode, wp_func_en, hold_reset_func_en;
   logic region_protected;
   logic [7:0] cmd_code, sr_wr_data, status_two;
   logic [1:0] sec_prog_sel;
   logic [6:0] sec_prog_addr;
   int num_errors, checks_done;
   fsr_status_two u_dut (.core_clk(core_clk), .resetn(resetn), .cmd_exec(cmd_exec), .cmd_code(cmd_code),
      .hold_reset_pulse(hold_reset_pulse), .jedec_reset_pulse(jedec_reset_pulse), .sr_wr_strobe(sr_wr_strobe),
      .sr_wr_data(sr_wr_data), .wel(wel), .status_guard_lo(status_guard_lo), .status_perm_lock(status_perm_lock),
      .wp_n(wp_n), .sr_wr_accept(sr_wr_accept), .sec_prog_strobe(sec_prog_strobe), .sec_prog_sel(sec_prog_sel),
      .sec_prog_addr(sec_prog_addr), .sec_prog_ok(sec_prog_ok), .quad_cmd_ok(quad_cmd_ok),
      .io2_data_mode(io2_data_mode), .io3_data_mode(io3_data_mode), .wp_func_en(wp_func_en),
      .hold_reset_func_en(hold_reset_func_en), .region_prot_raw(region_prot_raw),
      .region_protected(region_protected), .status_two(status_two));
   fsr_host_model u_host (.core_clk(core_clk), .cmd_exec(cmd_exec), .cmd_code(cmd_code), .quad_cmd_ok(quad_cmd_ok),
      .hold_reset_pulse(hold_reset_pulse), .jedec_reset_pulse(jedec_reset_pulse), .sr_wr_strobe(sr_wr_strobe),
      .sr_wr_data(sr_wr_data), .sr_wr_accept(sr_wr_accept), .sec_prog_strobe(sec_prog_strobe),
      .sec_prog_sel(sec_prog_sel), .sec_prog_addr(sec_prog_addr), .sec_prog_ok(sec_prog_ok));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic end_of_test();
      if (num_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test
   // order: wel, guard_lo, perm_lock, wp_n, raw protection
   task automatic set_lv(input logic [4:0] v);
      @(posedge core_clk);
      {wel, status_guard_lo, status_perm_lock, wp_n, region_prot_raw} <= v;
      #1;
   endtask : set_lv
   task automatic t_quad_gate();
      logic [7:0] ops [5] = '{fsr_pkg::OP_QUAD_OUT_READ, fsr_pkg::OP_XIP_READ, fsr_pkg::OP_QUAD_PAGE_PROG,
         fsr_pkg::OP_BURST_WRAP, fsr_pkg::OP_QUAD_ID_READ};
      logic ok;
      foreach (ops[i]) begin
         u_host.cmd(ops[i], ok);
         chk("quad cmd off", ok, 8'h00);
      end
      u_host.cmd(8'h03, ok);
      chk("plain cmd", ok, 8'h01);
   endtask : t_quad_gate
   task automatic t_suspend();
      logic ok;
      for (int k = 0; k < 4; k++) begin
         u_host.cmd(fsr_pkg::OP_SUSPEND, ok);
         chk("paused set", status_two, 8'h80);
         case (k)
            0: u_host.cmd(fsr_pkg::OP_RESUME, ok);
            1: begin
               u_host.cmd(fsr_pkg::OP_RESET_ENABLE, ok);
               u_host.cmd(fsr_pkg::OP_RESET_DEVICE, ok);
            end
            default: u_host.reset_event(k[0]);
         endcase
         chk("paused clear", status_two, 8'h00);
      end
   endtask : t_suspend
   task automatic t_security();
      logic ok;
      logic [7:0] exp;
      exp = 8'h00;
      u_host.prog(fsr_pkg::SEC_FACTORY_SEL, fsr_pkg::SEC_LAST_BYTE, ok);
      chk("factory prog", ok, 8'h00);
      for (int s = 1; s < 4; s++) begin
         u_host.prog(s[1:0], 7'h7e, ok);
         chk("open prog", ok, 8'h01);
         chk("no lock yet", status_two, exp);
         u_host.prog(s[1:0], fsr_pkg::SEC_LAST_BYTE, ok);
         exp[s+2] = 1'b1;
         chk("lock bits", status_two, exp);
         u_host.prog(s[1:0], 7'h00, ok);
         chk("locked prog", ok, 8'h00);
      end
   endtask : t_security
   task automatic t_write();
      logic ok;
      u_host.wr(8'hff, ok);
      chk("write no wel", ok, 8'h00);
      set_lv(5'b11000);
      u_host.wr(8'hff, ok);
      chk("write pin low", ok, 8'h00);
      set_lv(5'b11011);
      u_host.wr(8'h82, ok);
      chk("write pin high", ok, 8'h01);
      chk("ro bits kept", status_two, 8'h3a);
      chk("quad pins", {io2_data_mode, io3_data_mode, wp_func_en, hold_reset_func_en}, 8'h0c);
      // hold/reset pin is a data line now, so its pulse must not clear the flag
      u_host.cmd(fsr_pkg::OP_SUSPEND, ok);
      u_host.reset_event(1'b0);
      chk("hold ignored", status_two, 8'hba);
      u_host.cmd(fsr_pkg::OP_RESUME, ok);
      chk("resume in quad", status_two, 8'h3a);
      u_host.cmd(fsr_pkg::OP_XIP_READ, ok);
      chk("quad cmd on", ok, 8'h01);
      chk("region plain", region_protected, 8'h01);
      u_host.wr(8'h41, ok);
      chk("invert set", status_two, 8'h79);
      chk("region inverted", region_protected, 8'h00);
      u_host.wr(8'h00, ok);
      chk("lockdown write", ok, 8'h00);
      u_host.reset_event(1'b1);
      chk("lockdown freed", status_two, 8'h78);
      u_host.wr(8'h01, ok);
      chk("guard write", ok, 8'h01);
      chk("guard set", status_two, 8'h39);
      set_lv(5'b11111);
      u_host.reset_event(1'b1);
      u_host.wr(8'h40, ok);
      chk("perm write", ok, 8'h00);
      chk("perm kept", status_two, 8'h39);
      chk("region perm", region_protected, 8'h01);
   endtask : t_write
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      num_errors++;
      end_of_test();
   end
   initial begin
      resetn = 1'b0;
      {wel, status_guard_lo, status_perm_lock, wp_n, region_prot_raw} = 5'b00010;
      num_errors = 0;
      checks_done = 0;
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      #1;
      chk("reset status", status_two, 8'h00);
      chk("reset pins", {io2_data_mode, io3_data_mode, wp_func_en, hold_reset_func_en}, 8'h03);
      t_quad_gate();
      t_suspend();
      t_security();
      t_write();
      end_of_test();
   end
endmodule : tb
